// [cpu_stack.sv]
`include "cpu_stack_map.svh"
`default_nettype none
module cpu_stack (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // return stack
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [`PC_W-1:0] push_addr_i,
   input wire logic stk_err_en_i,
   output logic [`PC_W-1:0] top_addr_o,
   output logic stack_overflow_flag_o,
   output logic stack_underflow_flag_o,
   input wire logic flags_clr_i,
   output logic soft_reset_o,
   // context shadow
   input wire logic irq_enter_i,
   input wire logic irq_return_i,
   input wire logic [`CTX_W-1:0] ctx_i,
   output logic [`CTX_W-1:0] ctx_restore_o,
   output logic ctx_restore_vld_o,
   // indirect pointers
   input wire logic ptr_wr_i,
   input wire logic ptr_wr_sel_i,
   input wire logic [`PTR_W-1:0] ptr_wr_data_i,
   output logic [`PTR_W-1:0] ptr0_o,
   output logic [`PTR_W-1:0] ptr1_o,
   // operand addressing
   input wire cpu_stack_pkg::opnd_req_t req_i,
   output cpu_stack_pkg::opnd_ans_t ans_o,
   output logic busy_o
);
   // ==========================================
   // return stack
   logic [`PC_W-1:0] stk_mem_r [`STK_DEPTH];
   logic [`STK_AW:0] cnt_r;
   logic full, empty, do_push, do_pop, ovf_ev, unf_ev;
   assign full = (cnt_r == (`STK_AW+1)'(`STK_DEPTH));
   assign empty = (cnt_r == '0);
   assign ovf_ev = push_i && full;
   assign unf_ev = pop_i && !push_i && empty;
   assign do_push = push_i && !full;
   assign do_pop = pop_i && !push_i && !empty;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (do_push) begin
         stk_mem_r[cnt_r[`STK_AW-1:0]] <= push_addr_i;
         cnt_r <= cnt_r + 1'b1;
      end else if (do_pop) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         top_addr_o <= `PC_RST;
      end else if (do_push) begin
         top_addr_o <= push_addr_i;
      end else if (do_pop) begin
         top_addr_o <= (cnt_r > 1) ? stk_mem_r[cnt_r[`STK_AW-1:0] - 2'h2] : `PC_RST;
      end
   end

   // flags: set wins over clear
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         stack_overflow_flag_o <= 1'b0;
         stack_underflow_flag_o <= 1'b0;
         soft_reset_o <= 1'b0;
      end else begin
         stack_overflow_flag_o <= (stk_err_en_i && ovf_ev) ||
            (stack_overflow_flag_o && !flags_clr_i);
         stack_underflow_flag_o <= (stk_err_en_i && unf_ev) ||
            (stack_underflow_flag_o && !flags_clr_i);
         soft_reset_o <= stk_err_en_i && (ovf_ev || unf_ev);
      end
   end

   // ==========================================
   // context shadow
   logic [`CTX_W-1:0] shadow_r;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         shadow_r <= '0;
      end else if (irq_enter_i) begin
         shadow_r <= ctx_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctx_restore_o <= '0;
         ctx_restore_vld_o <= 1'b0;
      end else begin
         ctx_restore_vld_o <= irq_return_i;
         if (irq_return_i) begin
            ctx_restore_o <= shadow_r;
         end
      end
   end

   // ==========================================
   // indirect pointers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ptr0_o <= `PTR_RST;
         ptr1_o <= `PTR_RST;
      end else if (ptr_wr_i) begin
         if (ptr_wr_sel_i) begin
            ptr1_o <= ptr_wr_data_i;
         end else begin
            ptr0_o <= ptr_wr_data_i;
         end
      end
   end

   // ==========================================
   // operand addressing
   cpu_stack_pkg::ind_state_t st_r;
   logic [`PTR_W-1:0] eff;
   logic is_prog;
   always_comb begin
      eff = req_i.operand;
      unique case (req_i.mode)
         cpu_stack_pkg::AM_INDIRECT: eff = req_i.ptr_sel ? ptr1_o : ptr0_o;
         cpu_stack_pkg::AM_RELATIVE: eff = {1'b0, req_i.pc} + req_i.operand;
         default: eff = req_i.operand;
      endcase
   end
   assign is_prog = (req_i.mode == cpu_stack_pkg::AM_INDIRECT) && eff[`PROG_SEL_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_r <= cpu_stack_pkg::IND_IDLE;
         ans_o <= '0;
         busy_o <= 1'b0;
      end else begin
         unique case (st_r)
            cpu_stack_pkg::IND_IDLE: begin
               ans_o <= '0;
               busy_o <= 1'b0;
               if (req_i.valid && is_prog) begin
                  st_r <= cpu_stack_pkg::IND_FETCH;
                  busy_o <= 1'b1;
                  ans_o.prog <= 1'b1;
                  ans_o.addr <= eff;
               end else if (req_i.valid) begin
                  ans_o <= '{valid: 1'b1, prog: 1'b0, addr: eff};
               end
            end
            cpu_stack_pkg::IND_FETCH: begin
               st_r <= cpu_stack_pkg::IND_IDLE;
               busy_o <= 1'b0;
               ans_o.valid <= 1'b1;
            end
            default: st_r <= cpu_stack_pkg::IND_IDLE;
         endcase
      end
   end

   // ==========================================
   // checks
   ovf_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (stk_err_en_i && push_i && full) |=> stack_overflow_flag_o && soft_reset_o)
      else $error("overflow not flagged");
   unf_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (stk_err_en_i && pop_i && !push_i && empty) |=> stack_underflow_flag_o)
      else $error("underflow not flagged");
   depth_bound_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cnt_r <= (`STK_AW+1)'(`STK_DEPTH))
      else $error("stack depth exceeded");
   push_top_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (push_i && !full) |=> top_addr_o == $past(push_addr_i))
      else $error("top not pushed value");
   ctx_restore_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (irq_enter_i ##1 !irq_enter_i && irq_return_i) |=> ctx_restore_o == $past(ctx_i, 2))
      else $error("context not restored");
   prog_extra_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_r == cpu_stack_pkg::IND_IDLE && req_i.valid && is_prog)
      |=> !ans_o.valid && busy_o ##1 ans_o.valid && ans_o.prog)
      else $error("no extra cycle");
   data_direct_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_r == cpu_stack_pkg::IND_IDLE && req_i.valid && !is_prog)
      |=> ans_o.valid && !busy_o)
      else $error("data access late");
   ptr_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ptr_wr_i && !ptr_wr_sel_i) |=> ptr0_o == $past(ptr_wr_data_i))
      else $error("pointer not written");
   full_c: cover property (@(posedge clk_sys_i) full);
   ovf_c: cover property (@(posedge clk_sys_i) soft_reset_o);
   prog_c: cover property (@(posedge clk_sys_i) st_r == cpu_stack_pkg::IND_FETCH);
   ctx_c: cover property (@(posedge clk_sys_i) ctx_restore_vld_o);
endmodule
`default_nettype wire

// [cpu_stack_map.svh]
`ifndef CPU_STACK_MAP_SVH
`define CPU_STACK_MAP_SVH
`define STK_DEPTH 16
`define STK_AW 4
`define PC_W 15
`define PTR_W 16
`define CTX_W 32
`define PROG_SEL_BIT 15
`define PTR_RST 16'h0000
`define PC_RST 15'h0000
`endif

// [cpu_stack_pkg.sv]
`default_nettype none
package cpu_stack_pkg;
   typedef enum logic [1:0] {
      AM_DIRECT = 2'h0,
      AM_INDIRECT = 2'h1,
      AM_RELATIVE = 2'h3
   } addr_mode_t;

   typedef enum logic [1:0] {
      IND_IDLE = 2'h0,
      IND_FETCH = 2'h1
   } ind_state_t;

   typedef struct packed {
      logic valid;
      logic [1:0] mode;
      logic ptr_sel;
      logic [15:0] operand;
      logic [14:0] pc;
   } opnd_req_t;

   typedef struct packed {
      logic valid;
      logic prog;
      logic [15:0] addr;
   } opnd_ans_t;
endpackage
`default_nettype wire

// [cpu_stack_tb_top.sv]
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cpu_stack_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, rst_i = 1, push_i = 0, pop_i = 0, stk_err_en_i = 1, flags_clr_i = 0;
   logic irq_enter_i = 0, irq_return_i = 0, ptr_wr_i = 0, ptr_wr_sel_i = 0;
   logic [14:0] push_addr_i = 0, top_addr_o;
   logic [31:0] ctx_i = 0, ctx_restore_o;
   logic [15:0] ptr_wr_data_i = 0, ptr0_o, ptr1_o;
   logic stack_overflow_flag_o, stack_underflow_flag_o, soft_reset_o, ctx_restore_vld_o;
   logic busy_o, rd_vld;
   logic [7:0] rd_data;
   cpu_stack_pkg::opnd_req_t req_i = '0;
   cpu_stack_pkg::opnd_ans_t ans_o;
   int err_count = 0, checks = 0, i, n;
   logic [35:0] rows [3] = '{{2'h0, 15'h0, 3'h0, 16'h00AB},
      {2'h1, 15'h0, 3'h0, 16'h1234}, {2'h3, 15'h0100, 3'h0, 16'h0110}};
   cpu_stack i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .push_i(push_i), .pop_i(pop_i),
      .push_addr_i(push_addr_i), .stk_err_en_i(stk_err_en_i), .top_addr_o(top_addr_o),
      .stack_overflow_flag_o(stack_overflow_flag_o),
      .stack_underflow_flag_o(stack_underflow_flag_o), .flags_clr_i(flags_clr_i),
      .soft_reset_o(soft_reset_o), .irq_enter_i(irq_enter_i), .irq_return_i(irq_return_i),
      .ctx_i(ctx_i), .ctx_restore_o(ctx_restore_o), .ctx_restore_vld_o(ctx_restore_vld_o),
      .ptr_wr_i(ptr_wr_i), .ptr_wr_sel_i(ptr_wr_sel_i), .ptr_wr_data_i(ptr_wr_data_i),
      .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .req_i(req_i), .ans_o(ans_o), .busy_o(busy_o));
   prog_data_mem_model i_mem (.clk_sys_i(clk_sys_i), .ans_i(ans_o), .rd_data_o(rd_data),
      .rd_vld_o(rd_vld));
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // ==========================
   // helpers
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wait_sr(input logic exp);
      for (n = 0; n < 3 && soft_reset_o !== 1'b1; n++) tick();
      `CHK(n < 3, exp)
   endtask
   task automatic final_report();
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================
   // main sequence
   initial begin
      repeat (20) tick();
      rst_i = 0;
      `CHK({top_addr_o, stack_overflow_flag_o, busy_o, ptr0_o}, 32'h0)
      ptr_wr_i = 1;
      ptr_wr_data_i = 16'h1234;
      tick();
      ptr_wr_sel_i = 1;
      ptr_wr_data_i = 16'h8010;
      tick();
      ptr_wr_i = 0;
      `CHK({ptr0_o, ptr1_o}, 32'h1234_8010)
      for (i = 0; i < 3; i++) begin
         req_i = {1'b1, rows[i][35:34], 1'b0, ((i == 2) ? 16'h0010 : rows[i][15:0]),
            rows[i][33:19]};
         tick();
         `CHK({ans_o.valid, ans_o.prog, ans_o.addr}, {2'b10, rows[i][15:0]})
      end
      req_i = {1'b1, 2'h1, 1'b1, 16'h0, 15'h0};
      tick();
      req_i.valid = 0;
      `CHK({busy_o, ans_o.valid}, 2'b10)
      tick();
      `CHK({busy_o, ans_o.valid, ans_o.prog, ans_o.addr}, 19'h3_8010)
      tick();
      `CHK({rd_vld, rd_data}, 9'h1EF)
      push_i = 1;
      for (i = 0; i < 16; i++) begin
         push_addr_i = 15'(15'h100 + i);
         tick();
         `CHK(top_addr_o, 15'(15'h100 + i))
      end
      push_addr_i = 15'h7FFF;
      tick();
      push_i = 0;
      `CHK(top_addr_o, 15'h10F)
      wait_sr(1'b1);
      `CHK(stack_overflow_flag_o, 1'b1)
      pop_i = 1;
      for (i = 15; i >= 0; i--) begin
         tick();
         `CHK(top_addr_o, (i > 0) ? 15'(15'h0FF + i) : 15'h0)
      end
      tick();
      pop_i = 0;
      wait_sr(1'b1);
      `CHK(stack_underflow_flag_o, 1'b1)
      flags_clr_i = 1;
      stk_err_en_i = 0;
      tick();
      flags_clr_i = 0;
      pop_i = 1;
      tick();
      pop_i = 0;
      wait_sr(1'b0);
      `CHK({stack_overflow_flag_o, stack_underflow_flag_o}, 2'b00)
      ctx_i = 32'hA5A5_5A5A;
      irq_enter_i = 1;
      tick();
      irq_enter_i = 0;
      ctx_i = 32'h0F0F_F0F0;
      irq_return_i = 1;
      tick();
      irq_return_i = 0;
      `CHK({ctx_restore_vld_o, ctx_restore_o}, 33'h1_A5A5_5A5A)
      final_report();
   end
endmodule
`undef CHK
`default_nettype wire

// [prog_data_mem_model.sv]
`default_nettype none
module prog_data_mem_model (
   // clock
   input wire logic clk_sys_i,
   // answer from the block
   input wire cpu_stack_pkg::opnd_ans_t ans_i,
   // fetched word
   output logic [7:0] rd_data_o,
   output logic rd_vld_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================
   // memory read
   always_ff @(posedge clk_sys_i) begin
      rd_vld_o <= ans_i.valid;
      rd_data_o <= ans_i.prog ? ~ans_i.addr[7:0] : ans_i.addr[7:0];
   end
endmodule
`default_nettype wire
